// *** rtl/psr_pkg.sv ***
/*
  Package for the pipe-select and return-store fencing block: command encodings, function codes,
  field positions, register offsets and the flush/fence-event carrier structs.
  Assumes a 32-bit dword command stream and an AHB-Lite register bus.
*/
package psr_pkg;

  // ****************************************
  // shared function codes
  // ****************************************
  localparam logic [3:0] SFC_NULL = 4'h0;
  localparam logic [3:0] SFC_MATH = 4'h1;
  localparam logic [3:0] SFC_SAMPLER = 4'h2;
  localparam logic [3:0] SFC_GATEWAY = 4'h3;
  localparam logic [3:0] SFC_RETSTORE = 4'h6;
  localparam logic [3:0] SFC_SPAWNER = 4'h7;

  // ****************************************
  // fixed function codes
  // ****************************************
  localparam logic [3:0] FFC_NULL = 4'h0;
  localparam logic [3:0] FFC_SPAWNER = 4'h7;
  localparam logic [3:0] FFC_MEDIA_FRONT = 4'h8;
  localparam logic [3:0] FFC_VERTEX = 4'h9;
  localparam logic [3:0] FFC_CMD_STREAM = 4'ha;
  localparam logic [3:0] FFC_VERTEX_FETCH = 4'hb;
  localparam logic [3:0] FFC_GEOMETRY = 4'hc;
  localparam logic [3:0] FFC_CLIPPING = 4'hd;
  localparam logic [3:0] FFC_STRIP_FAN = 4'he;
  localparam logic [3:0] FFC_WINDOWER = 4'hf;

  // ****************************************
  // command header encodings
  // ****************************************
  localparam logic [2:0] CMD_TYPE_PIPE = 3'h3;
  localparam logic [1:0] CMD_SUBTYPE_COMMON = 2'h0;
  localparam logic [2:0] OPC_SELECT = 3'h1;
  localparam logic [7:0] SUBOPC_SELECT = 8'h04;
  localparam logic [2:0] OPC_FENCE = 3'h0;
  localparam logic [7:0] SUBOPC_FENCE = 8'h00;
  localparam logic [7:0] FENCE_LEN_FIELD = 8'h01;
  localparam int FENCE_LEN_BIAS = 2;
  localparam int REALLOC_LSB = 8;

  // ****************************************
  // return store geometry
  // ****************************************
  localparam int ROWS_SMALL = 256;
  localparam int ROWS_LARGE = 384;
  localparam int PTR_W = 11;

  // ****************************************
  // stage index order in the return store
  // ****************************************
  localparam int STG_VERTEX = 0;
  localparam int STG_GEOMETRY = 1;
  localparam int STG_CLIPPING = 2;
  localparam int STG_STRIP_FAN = 3;
  localparam int STG_MEDIA_FRONT = 4;
  localparam int STG_CMD_STREAM = 5;
  localparam int NUM_STG = 6;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTX = 8'h08;
  localparam logic [7:0] REG_FENCE_LO = 8'h0c;
  localparam logic [7:0] REG_FENCE_HI = 8'h10;
  localparam logic [7:0] REG_DONE = 8'h14;
  localparam logic [7:0] REG_CODES = 8'h18;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [0:0] {
    PIPE_3D = 1'b0,
    PIPE_MEDIA = 1'b1
  } psr_pipe_t;

  typedef struct packed {
    logic valid;
    psr_pipe_t pipe;
    logic release_constant;
  } psr_flush_t;

  typedef struct packed {
    logic [NUM_STG-1:0] apply;
    logic [NUM_STG-1:0] realloc;
  } psr_fence_ev_t;

endpackage

// *** rtl/psr_core.sv ***
/*
  Command-stream front end: pipe select, deallocating flush, region boundaries.
  Software writes command dwords one by one into the command register over AHB-Lite;
  the pipe stages report drain completion on a port. One clock, asynchronous active-low reset.
*/
// Function
// - 4-bit shared function codes: null, math, sampler, gateway, return store, spawner.
// - 4-bit fixed function codes for pipeline stages; 1 to 6 reserved.
// - Pipe select bit 0 picks 3D when 0, media when 1.
// - Pipe select header is type 3, subtype 0, opcode 1, sub-opcode 04.
// - A selection change sends a deallocating flush down the old pipe.
// - Windower drops constant entry; new boundaries wait until old entries freed.
// - The selection bit is saved and restored as context state.
// - Track the pipe holding the constant entry; leaving it forces deallocation.
// - Boundary pointers count 512-bit rows, pointing past the stage region.
// - Regions chain in fixed order from row 0; rows past last pointer unused.
// - Boundaries for stages of the unselected pipe are ignored.
// - Return store holds 256 or 384 rows, bounding every pointer.
// - Moving boundaries copies nothing; software reloads size-dependent state.
// - Fence header is type 3, subtype 0, opcode 0, sub-opcode 00, length bias 2.
// - Fence dwords 1 and 2 carry the six boundary pointers.
// - Header bits 13 to 8 request reallocation per stage.
// - Command stream boundary always applies.
`timescale 1ns/1ps

module psr_core #(
  parameter int ROWS = psr_pkg::ROWS_SMALL
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pipeline side
  output psr_pkg::psr_flush_t flush_o,
  input wire logic drain_done,
  output psr_pkg::psr_fence_ev_t fence_o,
  output logic [10:0] bound_vertex,
  output logic [10:0] bound_geometry,
  output logic [10:0] bound_clipping,
  output logic [10:0] bound_strip_fan,
  output logic [10:0] bound_media_front,
  output logic [10:0] bound_cmd_stream,
  output logic pipe_media
);

  // only the two store sizes have a defined pointer range
  if (ROWS != psr_pkg::ROWS_SMALL && ROWS != psr_pkg::ROWS_LARGE) begin : g_rows_chk
    $error("ROWS must be 256 or 384");
  end

  // ****************************************
  // bus decode
  // ****************************************
  logic wr_pend_r;
  logic [7:0] addr_r;
  wire take = hsel && hready && (htrans == psr_pkg::HTRANS_NONSEQ);
  wire wr_cmd = wr_pend_r && (addr_r == psr_pkg::REG_CMD);
  wire wr_ctx = wr_pend_r && (addr_r == psr_pkg::REG_CTX);
  wire busy;

  // commands stall the bus while a switch drains, keeping stream order
  assign hreadyout = !(wr_cmd && busy);
  assign hresp = 1'b0;

  // the address phase is latched here; the write itself lands in its data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hreadyout) begin
      wr_pend_r <= take && hwrite;
      addr_r <= take ? haddr : 8'h00;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  typedef enum logic [1:0] {
    ST_HEAD = 2'b00,
    ST_FENCE1 = 2'b01,
    ST_FENCE2 = 2'b10,
    ST_DRAIN = 2'b11
  } psr_state_t;

  psr_state_t st_r, st_nxt;
  logic pipe_r, pipe_nxt;
  logic const_pipe_r;
  logic const_valid_r;
  logic [5:0] realloc_r;
  logic [31:0] dw1_r;
  logic bad_cmd_r;
  logic [7:0] done_cnt_r;

  wire [31:0] cmd = hwdata;
  wire is_pipe_hdr = (cmd[31:29] == psr_pkg::CMD_TYPE_PIPE) && (cmd[28:27] == psr_pkg::CMD_SUBTYPE_COMMON);
  wire is_select = is_pipe_hdr && (cmd[26:24] == psr_pkg::OPC_SELECT)
    && (cmd[23:16] == psr_pkg::SUBOPC_SELECT);
  wire is_fence = is_pipe_hdr && (cmd[26:24] == psr_pkg::OPC_FENCE)
    && (cmd[23:16] == psr_pkg::SUBOPC_FENCE)
    && (cmd[7:0] == psr_pkg::FENCE_LEN_FIELD);
  wire sel_pipe = cmd[0];
  // a select for the pipe already current sends no flush
  wire switch_req = wr_cmd && (st_r == ST_HEAD) && is_select && (sel_pipe != pipe_r);

  assign busy = (st_r == ST_DRAIN);

  // a selection change parks the command path until the old pipe is empty
  always_comb begin
    st_nxt = st_r;
    pipe_nxt = pipe_r;
    case (st_r)
      ST_HEAD: begin
        if (switch_req) begin
          st_nxt = ST_DRAIN;
        end else if (wr_cmd && is_fence) begin
          st_nxt = ST_FENCE1;
        end
      end
      ST_FENCE1: begin
        if (wr_cmd) st_nxt = ST_FENCE2;
      end
      ST_FENCE2: begin
        if (wr_cmd) st_nxt = ST_HEAD;
      end
      ST_DRAIN: begin
        // new boundaries only after the old pipe has freed its entries
        if (drain_done) begin
          st_nxt = ST_HEAD;
          pipe_nxt = ~pipe_r;
        end
      end
      default: st_nxt = ST_HEAD;
    endcase
    // a context restore writes the selection bit directly
    if (wr_ctx) pipe_nxt = hwdata[0];
  end

  // ****************************************
  // flush and constant tracking
  // ****************************************
  wire const_leave = const_valid_r && (const_pipe_r == pipe_r);
  // the flush names the pipe being left, sampled before the switch lands
  wire flush_go = switch_req;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_o <= '0;
    end else begin
      flush_o.valid <= flush_go;
      flush_o.pipe <= psr_pkg::psr_pipe_t'(pipe_r);
      flush_o.release_constant <= flush_go && const_leave;
    end
  end

  // ****************************************
  // fence capture
  // ****************************************
  logic [10:0] bnd_r [psr_pkg::NUM_STG];
  // per-stage pointers and their next values
  wire [10:0] bnd_nxt [psr_pkg::NUM_STG];
  wire [5:0] apply_w;
  wire fence_fire = wr_cmd && (st_r == ST_FENCE2);
  wire [10:0] raw [psr_pkg::NUM_STG];
  wire [10:0] lim = 11'(ROWS);

  // pointers count 512-bit rows, each marking the row after its stage
  assign raw[psr_pkg::STG_VERTEX] = {1'b0, dw1_r[9:0]};
  assign raw[psr_pkg::STG_GEOMETRY] = {1'b0, dw1_r[19:10]};
  assign raw[psr_pkg::STG_CLIPPING] = {1'b0, dw1_r[29:20]};
  assign raw[psr_pkg::STG_STRIP_FAN] = {1'b0, cmd[9:0]};
  assign raw[psr_pkg::STG_MEDIA_FRONT] = {1'b0, cmd[19:10]};
  assign raw[psr_pkg::STG_CMD_STREAM] = cmd[30:20];

  genvar g;
  generate
    for (g = 0; g < psr_pkg::NUM_STG; g++) begin : g_stg
      localparam bit IS_MEDIA = (g == psr_pkg::STG_MEDIA_FRONT);
      localparam bit IS_CS = (g == psr_pkg::STG_CMD_STREAM);
      // stages of the unselected pipe keep their old pointer
      assign apply_w[g] = fence_fire && (IS_CS || (IS_MEDIA == pipe_r));
      // values past the store are clamped to its last row boundary
      assign bnd_nxt[g] = apply_w[g] ? ((raw[g] > lim) ? lim : raw[g]) : bnd_r[g];
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) bnd_r[g] <= 11'h000;
        else bnd_r[g] <= bnd_nxt[g];
      end
    end
  endgenerate

  // ****************************************
  // command side events
  // ****************************************
  // a header is only decoded while no command is half way through
  wire head_wr = wr_cmd && (st_r == ST_HEAD);
  wire fence_head = head_wr && is_fence;
  wire dw1_wr = wr_cmd && (st_r == ST_FENCE1);
  wire drain_end = busy && drain_done;
  wire cs_realloc = apply_w[psr_pkg::STG_CMD_STREAM] && realloc_r[psr_pkg::STG_CMD_STREAM];
  wire bad_unknown = head_wr && !is_select && !is_fence;
  wire bad_select = head_wr && is_select && (cmd[15:1] != 15'h0000);
  wire bad_fence = head_wr && is_fence && (cmd[15:14] != 2'h0);
  wire bad_hit = bad_unknown || bad_select || bad_fence;

  // ****************************************
  // state, context and fence registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_HEAD;
      pipe_r <= 1'b0;
      dw1_r <= 32'h0000_0000;
      realloc_r <= 6'h00;
      fence_o <= '0;
    end else begin
      st_r <= st_nxt;
      pipe_r <= pipe_nxt;
      if (fence_head) realloc_r <= cmd[13:8];
      if (dw1_wr) dw1_r <= cmd;
      // fence outputs are one-cycle pulses, rebuilt every cycle
      fence_o.apply <= apply_w;
      fence_o.realloc <= apply_w & realloc_r;
    end
  end

  // ****************************************
  // constant entry tracking and status
  // ****************************************
  // a drain or a command-stream reallocation drops the constant entry;
  // a fence that does neither leaves one behind for the pipe then selected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      const_valid_r <= 1'b0;
      const_pipe_r <= 1'b0;
    end else if (drain_end || cs_realloc) begin
      const_valid_r <= 1'b0;
    end else if (fence_fire) begin
      const_valid_r <= 1'b1;
      const_pipe_r <= pipe_r;
    end
  end

  // unknown commands are dropped and malformed selects or fences still execute; both leave a sticky mark
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_cmd_r <= 1'b0;
      done_cnt_r <= 8'h00;
    end else begin
      if (bad_hit) bad_cmd_r <= 1'b1;
      if (drain_end) done_cnt_r <= done_cnt_r + 8'h01;
    end
  end

  // ****************************************
  // outputs and read mux
  // ****************************************
  // boundaries drive the stages straight from their registers
  assign bound_vertex = bnd_r[psr_pkg::STG_VERTEX];
  assign bound_geometry = bnd_r[psr_pkg::STG_GEOMETRY];
  assign bound_clipping = bnd_r[psr_pkg::STG_CLIPPING];
  assign bound_strip_fan = bnd_r[psr_pkg::STG_STRIP_FAN];
  assign bound_media_front = bnd_r[psr_pkg::STG_MEDIA_FRONT];
  assign bound_cmd_stream = bnd_r[psr_pkg::STG_CMD_STREAM];
  assign pipe_media = pipe_r;

  wire [31:0] rd_status = {24'h000000, done_cnt_r[1:0], bad_cmd_r, const_pipe_r, const_valid_r, busy, st_r};
  wire [31:0] rd_lo = {2'b00, bnd_r[2][9:0], bnd_r[1][9:0], bnd_r[0][9:0]};
  wire [31:0] rd_hi = {1'b0, bnd_r[5], bnd_r[4][9:0], bnd_r[3][9:0]};
  wire [31:0] rd_codes = {16'h0000, psr_pkg::FFC_WINDOWER, psr_pkg::FFC_CMD_STREAM,
    psr_pkg::SFC_RETSTORE, psr_pkg::SFC_SPAWNER};
  // read data is picked in the address phase so it stands through the data phase
  wire [7:0] rd_addr = take && !hwrite ? haddr : 8'hff;
  wire [31:0] rd_sel = (rd_addr == psr_pkg::REG_STATUS) ? rd_status :
    (rd_addr == psr_pkg::REG_CTX) ? {31'h0, pipe_r} :
    (rd_addr == psr_pkg::REG_FENCE_LO) ? rd_lo :
    (rd_addr == psr_pkg::REG_FENCE_HI) ? rd_hi :
    (rd_addr == psr_pkg::REG_DONE) ? {24'h000000, done_cnt_r} :
    (rd_addr == psr_pkg::REG_CODES) ? rd_codes : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) hrdata <= 32'h0000_0000;
    else if (hreadyout) hrdata <= rd_sel;
  end

endmodule

// *** tb/psr_core_assertions.sv ***
/*
  Checker for psr_core: flush, fence and bus-response relations.
  Assumes it is bound onto psr_core and sees only its ports.
*/
`timescale 1ns/1ps
module psr_core_checker #(
  parameter int ROWS = 256
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic hresp,
  input wire logic drain_done,
  input wire psr_pkg::psr_flush_t flush_o,
  input wire psr_pkg::psr_fence_ev_t fence_o,
  input wire logic [10:0] bound_vertex,
  input wire logic [10:0] bound_clipping,
  input wire logic [10:0] bound_cmd_stream,
  input wire logic pipe_media
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_flush_pulse: assert property (flush_o.valid |=> !flush_o.valid) else $error("flush too long");
  chk_flush_old: assert property (flush_o.valid |-> flush_o.pipe == pipe_media)
    else $error("flush on wrong pipe");
  chk_switch_waits: assert property (flush_o.valid ##1 !drain_done |=> $stable(pipe_media))
    else $error("pipe changed before drain");
  chk_const_pair: assert property (flush_o.release_constant |-> flush_o.valid)
    else $error("constant release without flush");
  chk_cs_applied: assert property (|fence_o.apply |-> fence_o.apply[5]) else $error("cs bound skipped");
  chk_unsel_skip: assert property (|fence_o.apply |->
    (pipe_media ? fence_o.apply[3:0] == 4'h0 : !fence_o.apply[4])) else $error("unselected bound applied");
  chk_bound_max: assert property (bound_cmd_stream <= ROWS && bound_clipping <= ROWS)
    else $error("bound beyond store");
  chk_bound_cause: assert property ($changed(bound_vertex) |-> fence_o.apply[0])
    else $error("vertex bound moved without fence");
  chk_fence_pulse: assert property (|fence_o.apply |=> fence_o.apply == 6'h00)
    else $error("fence pulse too long");
endmodule

bind psr_core psr_core_checker #(.ROWS(ROWS)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .hresp(hresp),
  .drain_done(drain_done), .flush_o(flush_o), .fence_o(fence_o), .bound_vertex(bound_vertex),
  .bound_clipping(bound_clipping), .bound_cmd_stream(bound_cmd_stream), .pipe_media(pipe_media));

// *** tb/psr_stage_model.sv ***
/*
  Model of the pipe stages: drains after a deallocating flush.
  Assumes flush_o.valid is a one-cycle pulse from psr_core.
*/
`timescale 1ns/1ps
module psr_stage_model #(
  parameter int DELAY = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // flush in, drain out
  input wire psr_pkg::psr_flush_t flush_o,
  output logic drain_done
);
  // ****************************************
  // drain timer
  // ****************************************
  int cnt;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      drain_done <= 1'b0;
    end else begin
      // stages finish their tasks, windower drops the constant, then entries are free
      drain_done <= (cnt == 1);
      if (flush_o.valid) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// *** tb/psr_core_tb_top.sv ***
/*
  Testbench for psr_core: AHB-Lite command writes, register reads, pipe switches.
  Assumes psr_stage_model on the pipe side and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module psr_core_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n, hsel, hwrite, hreadyout, hresp, pipe_media, drain_done;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d;
  logic [10:0] b_vx, b_gs, b_cl, b_sf, b_mf, b_cs;
  psr_pkg::psr_flush_t flush_o, fl_last;
  psr_pkg::psr_fence_ev_t fence_o, fe_last;
  int error_cnt = 0, total_checks = 0, fl_cnt = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  psr_core #(.ROWS(256)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flush_o(flush_o), .drain_done(drain_done), .fence_o(fence_o), .bound_vertex(b_vx),
    .bound_geometry(b_gs), .bound_clipping(b_cl), .bound_strip_fan(b_sf), .bound_media_front(b_mf),
    .bound_cmd_stream(b_cs), .pipe_media(pipe_media));
  psr_stage_model #(.DELAY(5)) u_stg (.ref_clk(ref_clk), .rst_n(rst_n), .flush_o(flush_o), .drain_done(drain_done));
  // ****************************************
  // monitors and tasks
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    if (flush_o.valid === 1'b1) begin
      fl_cnt++;
      fl_last = flush_o;
    end
    if (|fence_o.apply) fe_last = fence_o;
    if (cyc == 5000) begin
      $display("wrong value at %0t: run timed out", $time);
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= psr_pkg::HTRANS_NONSEQ;
    @(posedge ref_clk iff hreadyout === 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge ref_clk iff hreadyout === 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fence(input logic [31:0] h, input logic [31:0] lo, input logic [31:0] hi);
    wr(psr_pkg::REG_CMD, h);
    wr(psr_pkg::REG_CMD, lo);
    wr(psr_pkg::REG_CMD, hi);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic sel(input logic [31:0] c);
    wr(psr_pkg::REG_CMD, c);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    xfer(psr_pkg::REG_CODES, 1'b0, 32'h0, d);
    chk(d & 32'hffff, 32'h0000fa67);
    xfer(8'h40, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    $display("test codes done");
    fence(32'h60002101, 32'h06010020, 32'h7ff24080);
    chk(b_vx, 32'h20);
    chk(b_gs, 32'h40);
    chk(b_cl, 32'h60);
    chk(b_sf, 32'h80);
    chk(b_cs, 32'h100);
    chk(fe_last.apply, 32'h2f);
    chk(fe_last.realloc, 32'h21);
    $display("test fence 3d done");
    sel(32'h61040001);
    chk(pipe_media, 32'h1);
    chk(fl_cnt, 32'h1);
    chk(fl_last.pipe, 32'h0);
    chk(fl_last.release_constant, 32'h0);
    fence(32'h60000001, 32'h00000010, 32'h0c028080);
    chk(b_vx, 32'h20);
    chk(b_mf, 32'ha0);
    chk(b_cs, 32'hc0);
    chk(fe_last.apply, 32'h30);
    sel(32'h61040001);
    chk(fl_cnt, 32'h1);
    wr(psr_pkg::REG_CMD, 32'h61040000);
    wr(psr_pkg::REG_CMD, 32'h61040000);
    chk(pipe_media, 32'h0);
    chk(fl_cnt, 32'h2);
    chk(fl_last.pipe, 32'h1);
    chk(fl_last.release_constant, 32'h1);
    $display("test pipe switch done");
    wr(psr_pkg::REG_CTX, 32'h1);
    xfer(psr_pkg::REG_CTX, 1'b0, 32'h0, d);
    chk(d & 32'h1, 32'h1);
    chk(pipe_media, 32'h1);
    wr(psr_pkg::REG_CTX, 32'h0);
    wr(psr_pkg::REG_CMD, 32'h20000000);
    xfer(psr_pkg::REG_STATUS, 1'b0, 32'h0, d);
    chk(d[5], 32'h1);
    chk(pipe_media, 32'h0);
    $display("test context done");
    report_and_stop();
  end
endmodule
